// *** bench/pdw_ctrl_props.sv ***
// Checker for the power-down controller: mode entry, flags, port hold, settling.
// Assumes it is bound to pdw_ctrl and sees only that module's ports.
module pdw_ctrl_chk
import pdw_pkg::*;
#(
   parameter int PORT_W = PORT_A_W,
   parameter int IRQ_N = IRQ_W,
   parameter int SETTLE_CYC = OSC_SETTLE_CYC
)
(
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic HALT_EXEC,
   input wire logic CLR_WDT_EXEC,
   input wire logic HIGH_CLK_IDLE_ENABLE,
   input wire logic LOW_CLK_IDLE_ENABLE,
   input wire logic [2:0] WDT_TIMEOUT_SELECT,
   input wire logic [PORT_W-1:0] PORT_A_WAKE_ENABLE,
   input wire logic [PORT_W-1:0] PORT_A_PIN,
   input wire logic [IRQ_N-1:0] IRQ_REQ,
   input wire logic [IRQ_N-1:0] IRQ_ENABLE,
   input wire logic STACK_FULL,
   input wire logic [PORT_W-1:0] PORT_OUT_IN,
   input wire logic [PORT_W-1:0] PORT_DIR_IN,
   input wire pdw_pkg::pdw_clk_s CLK_CTRL,
   input wire pdw_pkg::pdw_wake_s WAKE_INFO,
   input wire logic [PORT_W-1:0] PORT_OUT,
   input wire logic [PORT_W-1:0] PORT_DIR,
   input wire logic POWER_DOWN_FLAG,
   input wire logic WATCHDOG_TIMEOUT_FLAG,
   input wire logic WDT_RESET,
   input wire pdw_pkg::pdw_state_e MODE
);
   int settle_cnt_ff;
   logic go;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // Halt only counts while running; elsewhere it is refused
   assign go = HALT_EXEC && MODE == PDW_RUN;
   // Length of the settle phase, checked when it ends
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         settle_cnt_ff <= 0;
      else if (MODE == PDW_SETTLE)
         settle_cnt_ff <= settle_cnt_ff + 1;
      else
         settle_cnt_ff <= 0;
   end
   chk_enter_sleep: assert property (
      go && !HIGH_CLK_IDLE_ENABLE && !LOW_CLK_IDLE_ENABLE |=> MODE == PDW_SLEEP
      && !CLK_CTRL.high_clk_on && !CLK_CTRL.low_clk_on) else $error("sleep entry wrong");
   chk_enter_idle_mode_zero: assert property (
      go && !HIGH_CLK_IDLE_ENABLE && LOW_CLK_IDLE_ENABLE |=> MODE == PDW_IDLE_MODE_ZERO
      && !CLK_CTRL.high_clk_on && CLK_CTRL.low_clk_on) else $error("idle zero entry wrong");
   chk_enter_idle_mode_one: assert property (
      go && HIGH_CLK_IDLE_ENABLE && LOW_CLK_IDLE_ENABLE |=> MODE == PDW_IDLE_MODE_ONE
      && CLK_CTRL.high_clk_on && CLK_CTRL.low_clk_on) else $error("idle one entry wrong");
   chk_enter_idle_mode_two: assert property (
      go && HIGH_CLK_IDLE_ENABLE && !LOW_CLK_IDLE_ENABLE |=> MODE == PDW_IDLE_MODE_TWO
      && CLK_CTRL.high_clk_on && !CLK_CTRL.low_clk_on) else $error("idle two entry wrong");
   chk_halt_flags: assert property (
      go |=> POWER_DOWN_FLAG && CLK_CTRL.cpu_halted) else $error("halt flags wrong");
   chk_clr_pdf: assert property (
      MODE == PDW_RUN && CLR_WDT_EXEC && !HALT_EXEC |=> !POWER_DOWN_FLAG) else $error("flag not cleared");
   chk_port_hold: assert property (
      MODE != PDW_RUN && $past(MODE) != PDW_RUN |-> $stable(PORT_OUT) && $stable(PORT_DIR))
      else $error("port state moved");
   chk_settle_len: assert property (
      MODE == PDW_RUN && $past(MODE) == PDW_SETTLE |-> settle_cnt_ff == SETTLE_CYC)
      else $error("settle length wrong");
   chk_wake_from_low: assert property (
      $rose(MODE == PDW_SETTLE) |-> $past(MODE) inside {PDW_SLEEP, PDW_IDLE_MODE_ZERO, PDW_IDLE_MODE_ONE, PDW_IDLE_MODE_TWO})
      else $error("settle without low power");
   chk_resume_pulse: assert property (
      WAKE_INFO.resume_next |-> MODE == PDW_RUN ##1 !WAKE_INFO.resume_next) else $error("resume pulse wrong");
   chk_wdt_no_rst: assert property (
      MODE inside {PDW_SLEEP, PDW_IDLE_MODE_ZERO, PDW_IDLE_MODE_ONE, PDW_IDLE_MODE_TWO} |=> !WDT_RESET)
      else $error("reset pulse in low power");
   chk_wdt_wake_to: assert property (
      WAKE_INFO.pc_sp_reset |-> WATCHDOG_TIMEOUT_FLAG && !WAKE_INFO.resume_next)
      else $error("watchdog wake flags wrong");
   cover property (MODE == PDW_SLEEP);
   cover property (WAKE_INFO.pc_sp_reset);
   cover property ($rose(MODE == PDW_SETTLE));
   cover property (WAKE_INFO.irq_defer);
endmodule

bind pdw_ctrl pdw_ctrl_chk #(.PORT_W(PORT_W), .IRQ_N(IRQ_N), .SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

// *** bench/pdw_ctrl_tb.sv ***
// Testbench for pdw_ctrl: mode entry, port hold, flags and wake sources.
// Assumes a 25 MHz core clock, settling cut to four cycles and a sped-up slow oscillator.
`define CHK(a, b) \
begin \
   n_checks++; \
   if ((a) !== (b)) \
   begin \
      err_count++; \
      $display("ERROR %0t: got %0h expected %0h", $time, a, b); \
   end \
end
module pdw_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pdw_pkg::*;
   logic clk = 0, rst = 1, halt = 0, clr = 0, hien = 0, loen = 0, st_full = 0;
   logic [2:0] wsel = 3'h3;
   logic [7:0] wake_en = 8'h01, pins = 8'hFF, pout = 8'h00, pdir = 8'h00, port_out, port_dir;
   logic [3:0] irq = 4'h0, irq_en = 4'h0;
   logic power_down_flag, tof, wdt_rst;
   pdw_clk_s clk_ctrl;
   pdw_wake_s wake;
   pdw_state_e mode;
   int err_count = 0, n_checks = 0, cyc = 0;
   // Settle and slow oscillator shortened so wakes and watchdog overflows cost few cycles
   pdw_ctrl #(.SETTLE_CYC(4), .OSC_HALF_CYC(2)) uut (.CORE_CLK(clk), .RESET(rst), .HALT_EXEC(halt),
      .CLR_WDT_EXEC(clr),
      .HIGH_CLK_IDLE_ENABLE(hien), .LOW_CLK_IDLE_ENABLE(loen), .WDT_TIMEOUT_SELECT(wsel),
      .PORT_A_WAKE_ENABLE(wake_en), .PORT_A_PIN(pins), .IRQ_REQ(irq), .IRQ_ENABLE(irq_en),
      .STACK_FULL(st_full), .PORT_OUT_IN(pout), .PORT_DIR_IN(pdir), .CLK_CTRL(clk_ctrl),
      .WAKE_INFO(wake), .PORT_OUT(port_out), .PORT_DIR(port_dir), .POWER_DOWN_FLAG(power_down_flag),
      .WATCHDOG_TIMEOUT_FLAG(tof), .WDT_RESET(wdt_rst), .MODE(mode));
   always #20 clk = ~clk;
   // Ends the run once, from the main sequence or the hang limit
   task automatic give_verdict;
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Pulse halt for one edge with the chosen idle enables
   task automatic halt_in(input logic h, input logic l);
      @(posedge clk);
      hien <= h;
      loen <= l;
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      #1;
   endtask
   // Bounded wait for the end-of-wake pulse, then judge it
   task automatic wait_wake(input pdw_wake_s exp);
      int n;
      n = 0;
      while (wake === 3'h0 && n < 1200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(wake, exp)
      `CHK(mode, PDW_RUN)
   endtask
   // All four halt variants, with ports held and clear refused
   task automatic t_modes;
      pdw_state_e em[4] = '{PDW_SLEEP, PDW_IDLE_MODE_ZERO, PDW_IDLE_MODE_TWO, PDW_IDLE_MODE_ONE};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         pout <= 8'hA5 ^ 8'(i);
         pdir <= 8'h3C;
         halt_in(i[1], i[0]);
         `CHK(mode, em[i])
         `CHK(clk_ctrl, {i[1], i[0], 1'b1})
         `CHK(power_down_flag, 1'b1)
         `CHK(tof, 1'b0)
         @(posedge clk);
         pout <= 8'h00;
         pdir <= 8'hFF;
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
         `CHK(port_out, 8'hA5 ^ 8'(i))
         `CHK(port_dir, 8'h3C)
         `CHK(power_down_flag, 1'b1)
         @(posedge clk);
         pins <= 8'hFE;
         wait_wake(3'h2);
         @(posedge clk);
         pins <= 8'hFF;
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         #1;
         `CHK(port_out, 8'h00)
         `CHK(power_down_flag, 1'b0)
      end
   endtask
   // A disabled pin must not wake; the enabled one must
   task automatic t_pin_mask;
      @(posedge clk);
      wake_en <= 8'h80;
      halt_in(1'b1, 1'b1);
      @(posedge clk);
      pins <= 8'hFE;
      repeat (10) @(posedge clk);
      #1;
      `CHK(mode, PDW_IDLE_MODE_ONE)
      @(posedge clk);
      pins <= 8'h7E;
      wait_wake(3'h2);
      @(posedge clk);
      pins <= 8'hFF;
   endtask
   // Pending request ignored; new ones wake, service deferred while disabled or stack full, else not
   task automatic t_irq;
      @(posedge clk);
      irq <= 4'h1;
      irq_en <= 4'h4;
      st_full <= 1'b1;
      repeat (3) @(posedge clk);
      halt_in(1'b0, 1'b1);
      repeat (10) @(posedge clk);
      #1;
      `CHK(mode, PDW_IDLE_MODE_ZERO)
      @(posedge clk);
      irq <= 4'h3;
      wait_wake(3'h3);
      @(posedge clk);
      irq <= 4'h0;
      repeat (3) @(posedge clk);
      halt_in(1'b1, 1'b0);
      @(posedge clk);
      irq <= 4'h4;
      wait_wake(3'h3);
      @(posedge clk);
      irq <= 4'h0;
      st_full <= 1'b0;
      repeat (3) @(posedge clk);
      halt_in(1'b1, 1'b1);
      @(posedge clk);
      irq <= 4'h4;
      wait_wake(3'h2);
      @(posedge clk);
      irq <= 4'h0;
   endtask
   // Halt restarts the watchdog; overflow wakes from sleep, resets when running
   task automatic t_wdt;
      int n;
      n = 0;
      @(posedge clk);
      wsel <= 3'h0;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (600) @(posedge clk);
      halt_in(1'b0, 1'b0);
      repeat (600) @(posedge clk);
      #1;
      `CHK(mode, PDW_SLEEP)
      wait_wake(3'h4);
      `CHK(tof, 1'b1)
      `CHK(power_down_flag, 1'b1)
      while (wdt_rst !== 1'b1 && n < 1200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(wdt_rst, 1'b1)
      `CHK(tof, 1'b1)
   endtask
   // Hang limit about twice the few thousand cycles the tests need, mostly the watchdog test
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         err_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK(mode, PDW_RUN)
      `CHK(power_down_flag, 1'b0)
      t_modes();
      t_pin_mask();
      t_irq();
      t_wdt();
      give_verdict();
   end
endmodule

// *** hdl/pdw_ctrl.sv ***
// Power-down and wake-up controller: mode select, flags, watchdog, wake sequencing.
// Assumes the CPU pulses HALT_EXEC/CLR_WDT_EXEC and freezes itself while CLK_CTRL.cpu_halted is high.
// Assumes Port A pins and interrupt lines come from outside the core clock domain.
// Function
// R01: Halt with high 0, low 1 enters idle zero: high clock off.
// R02: Halt with both enables 1 enters idle one: clocks on, CPU halted.
// R03: Halt with high 1, low 0 enters idle two: low clock off.
// R04: Idle stops execution at halt; memory and registers keep values.
// R05: Port outputs and directions hold while in any idle mode.
// R06: Halt sets power-down flag and clears watchdog time-out flag.
// R07: Entering low power clears the watchdog, which keeps counting.
// R08: Wake on enabled Port A fall, interrupt, or watchdog overflow.
// R09: Power-up and clear-watchdog instruction clear the power-down flag.
// R10: Overflow in low power sets time-out, resets only PC and stack.
// R11: Each Port A pin has its own wake enable for falling edges.
// R12: Port A wake resumes at instruction after halt.
// R13: Disabled interrupt wake resumes after halt; service deferred until enabled.
// R14: Interrupt already pending at entry cannot wake that period.
// R15: Wake waits for system oscillator to restart and settle.
// R16: Watchdog clock is slow oscillator divided by eight.
// R17: Watchdog divider ratio 2^5 to 2^11 chosen by three-bit select.
// R18: Halt with both enables 0 enters sleep: all off except watchdog.
// R19: Wake sources detected while clock stopped, synchronised into core clock.
module pdw_ctrl
#(
   parameter int PORT_W = pdw_pkg::PORT_A_W,
   parameter int IRQ_N = pdw_pkg::IRQ_W,
   parameter int SETTLE_CYC = pdw_pkg::OSC_SETTLE_CYC,
   parameter int OSC_HALF_CYC = pdw_pkg::LOW_OSC_HALF_CYC
)
(
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic HALT_EXEC,
   input wire logic CLR_WDT_EXEC,
   input wire logic HIGH_CLK_IDLE_ENABLE,
   input wire logic LOW_CLK_IDLE_ENABLE,
   input wire logic [2:0] WDT_TIMEOUT_SELECT,
   input wire logic [PORT_W-1:0] PORT_A_WAKE_ENABLE,
   input wire logic [PORT_W-1:0] PORT_A_PIN,
   input wire logic [IRQ_N-1:0] IRQ_REQ,
   input wire logic [IRQ_N-1:0] IRQ_ENABLE,
   input wire logic STACK_FULL,
   input wire logic [PORT_W-1:0] PORT_OUT_IN,
   input wire logic [PORT_W-1:0] PORT_DIR_IN,
   output pdw_pkg::pdw_clk_s CLK_CTRL,
   output pdw_pkg::pdw_wake_s WAKE_INFO,
   output logic [PORT_W-1:0] PORT_OUT,
   output logic [PORT_W-1:0] PORT_DIR,
   output logic POWER_DOWN_FLAG,
   output logic WATCHDOG_TIMEOUT_FLAG,
   output logic WDT_RESET,
   output pdw_pkg::pdw_state_e MODE
);
   import pdw_pkg::*;

   // Refuse parameter values the counters cannot serve
   initial
   begin
      if (PORT_W < 1 || PORT_W > 32) $error("pdw_ctrl: PORT_W out of range");
      if (IRQ_N < 1) $error("pdw_ctrl: IRQ_N must be positive");
      if (SETTLE_CYC < 1) $error("pdw_ctrl: SETTLE_CYC must be at least 1");
      if (OSC_HALF_CYC < 1) $error("pdw_ctrl: OSC_HALF_CYC must be at least 1");
   end

   // Counter widths; the slow divider must hold a whole period, not just half of it
   localparam int SET_W = $clog2(SETTLE_CYC + 1);
   localparam int OSC_W = $clog2(2 * OSC_HALF_CYC);
   localparam logic [OSC_W-1:0] OSC_TOP = OSC_W'(2 * OSC_HALF_CYC - 1);
   localparam logic [SET_W-1:0] SET_TOP = SET_W'(SETTLE_CYC - 1);

   // Sequencer state, synchroniser stages and counters
   pdw_state_e state_ff;
   pdw_state_e nxt_state;
   logic [PORT_W-1:0] pin_s1_ff;
   logic [PORT_W-1:0] pin_s2_ff;
   logic [IRQ_N-1:0] irq_s1_ff;
   logic [IRQ_N-1:0] irq_s2_ff;
   logic [SET_W-1:0] settle_ff;
   logic [OSC_W-1:0] osc_ff;
   logic osc_tick;
   // Internal strobes and wake bookkeeping
   logic low_power;
   logic enter;
   logic wdt_clear;
   logic clr_cmd;
   logic wdt_ovf;
   logic pin_wake;
   logic irq_wake;
   logic wake_any;
   logic wake_by_wdt_ff;
   logic wake_by_irq_ff;
   logic irq_serviceable;

   // Mode chosen from the two idle enables at the halt
   function automatic pdw_state_e mode_of(input logic hi, input logic lo);
      case ({hi, lo})
         2'b01: mode_of = PDW_IDLE_MODE_ZERO; // R01
         2'b11: mode_of = PDW_IDLE_MODE_ONE; // R02
         2'b10: mode_of = PDW_IDLE_MODE_TWO; // R03
         default: mode_of = PDW_SLEEP; // R18
      endcase
   endfunction

   // Any of the four halted variants; settling does not count as low power
   function automatic logic is_low_power(input pdw_state_e s);
      is_low_power = (s == PDW_SLEEP) || (s == PDW_IDLE_MODE_ZERO) || (s == PDW_IDLE_MODE_ONE) || (s == PDW_IDLE_MODE_TWO);
   endfunction

   // Slow oscillator modelled as a tick that runs in every mode; the watchdog counts it even in idle two and sleep
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         osc_ff <= '0;
      else if (osc_ff == OSC_TOP)
         osc_ff <= '0;
      else
         osc_ff <= osc_ff + 1'b1;
   end
   assign osc_tick = (osc_ff == '0);

   // Halt and clear instructions only count while running; elsewhere the CPU is frozen
   assign low_power = is_low_power(state_ff);
   assign enter = (state_ff == PDW_RUN) && HALT_EXEC;
   assign clr_cmd = (state_ff == PDW_RUN) && CLR_WDT_EXEC;
   assign wdt_clear = enter || clr_cmd; // R07

   // Pin synchroniser; reset high so an idle pulled-up pin shows no false fall
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         pin_s1_ff <= '1;
         pin_s2_ff <= '1;
      end
      else
      begin
         pin_s1_ff <= PORT_A_PIN; // R19
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // Interrupt synchroniser; requests are raised in other clock domains
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         irq_s1_ff <= '0;
         irq_s2_ff <= '0;
      end
      else
      begin
         irq_s1_ff <= IRQ_REQ; // R19
         irq_s2_ff <= irq_s1_ff;
      end
   end

   // Watchdog runs in every state; only a halt or the clear instruction restarts it
   pdw_wdt #(
      .SEL_W(3)
   ) u_wdt (
      .clk(CORE_CLK),
      .rst(RESET),
      .osc_tick(osc_tick),
      .wdt_clear(wdt_clear),
      .sel(WDT_TIMEOUT_SELECT),
      .overflow(wdt_ovf)
   );

   // Edge and interrupt detector, armed afresh at each halt
   pdw_wake_det #(
      .PW(PORT_W),
      .IW(IRQ_N)
   ) u_wake (
      .clk(CORE_CLK),
      .rst(RESET),
      .arm(enter),
      .pin_sync(pin_s2_ff),
      .wake_en(PORT_A_WAKE_ENABLE),
      .irq_req(irq_s2_ff),
      .pin_wake(pin_wake),
      .irq_wake(irq_wake)
   );

   // Any source ends low power; a second source during settling is not needed
   assign wake_any = low_power && (pin_wake || irq_wake || wdt_ovf); // R08

   // Mode sequencer
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         PDW_RUN:
         begin
            if (HALT_EXEC)
               nxt_state = mode_of(HIGH_CLK_IDLE_ENABLE, LOW_CLK_IDLE_ENABLE);
         end
         PDW_SLEEP, PDW_IDLE_MODE_ZERO, PDW_IDLE_MODE_ONE, PDW_IDLE_MODE_TWO:
         begin
            if (wake_any)
               nxt_state = PDW_SETTLE; // R15
         end
         PDW_SETTLE:
         begin
            if (settle_ff == '0)
               nxt_state = PDW_RUN;
         end
         default: nxt_state = PDW_RUN;
      endcase
   end

   // State register
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         state_ff <= PDW_RUN;
      else
         state_ff <= nxt_state;
   end

   // Oscillator settle wait; idle one/two keep high clock, but we wait uniformly for simplicity
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         settle_ff <= '0;
      else if (wake_any)
         settle_ff <= SET_TOP; // R15
      else if (settle_ff != '0)
         settle_ff <= settle_ff - 1'b1;
   end

   // Watchdog cause latched at the wake edge; the overflow pulse is gone by the end
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         wake_by_wdt_ff <= 1'b0;
      else if (wake_any)
         wake_by_wdt_ff <= wdt_ovf; // R10
   end

   // Interrupt cause; an overflow in the same cycle takes precedence
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         wake_by_irq_ff <= 1'b0;
      else if (wake_any)
         wake_by_irq_ff <= irq_wake && !wdt_ovf; // R13
   end

   // Immediate service needs the request enabled and a free stack slot
   assign irq_serviceable = |(irq_s2_ff & IRQ_ENABLE) && !STACK_FULL; // R13

   // Power-down flag: halt sets, clear-watchdog clears, power-up clears
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         POWER_DOWN_FLAG <= 1'b0; // R09
      else if (enter)
         POWER_DOWN_FLAG <= 1'b1; // R06
      else if (clr_cmd)
         POWER_DOWN_FLAG <= 1'b0; // R09
   end

   // Time-out flag: overflow sets and wins over the halt clear
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         WATCHDOG_TIMEOUT_FLAG <= 1'b0;
      else if (wdt_ovf)
         WATCHDOG_TIMEOUT_FLAG <= 1'b1; // R10
      else if (enter)
         WATCHDOG_TIMEOUT_FLAG <= 1'b0; // R06
   end

   // Full reset outside low power, settling included, so no overflow is lost; in low power it wakes
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         WDT_RESET <= 1'b0;
      else
         WDT_RESET <= wdt_ovf && !low_power; // R10
   end

   // Mode mirrors the next state so it lines up with the internal state
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         MODE <= PDW_RUN;
      else
         MODE <= nxt_state;
   end

   // Clock gating and halt indication
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         CLK_CTRL <= '{high_clk_on: 1'b1, low_clk_on: 1'b1, cpu_halted: 1'b0};
      else
      begin
         CLK_CTRL.cpu_halted <= (nxt_state != PDW_RUN); // R04
         CLK_CTRL.high_clk_on <= !(nxt_state == PDW_SLEEP || nxt_state == PDW_IDLE_MODE_ZERO); // R01 R18
         CLK_CTRL.low_clk_on <= !(nxt_state == PDW_SLEEP || nxt_state == PDW_IDLE_MODE_TWO); // R03 R18
      end
   end

   // Wake outcome, one-cycle pulses as settling ends
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
         WAKE_INFO <= '0;
      else
      begin
         WAKE_INFO <= '0;
         if (state_ff == PDW_SETTLE && settle_ff == '0)
         begin
            WAKE_INFO.pc_sp_reset <= wake_by_wdt_ff; // R10
            WAKE_INFO.resume_next <= !wake_by_wdt_ff; // R12 R13
            WAKE_INFO.irq_defer <= wake_by_irq_ff && !irq_serviceable; // R13
         end
      end
   end

   // Port state frozen from the halt until run resumes
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         PORT_OUT <= '0;
         PORT_DIR <= '0;
      end
      else if (state_ff == PDW_RUN && !HALT_EXEC)
      begin
         PORT_OUT <= PORT_OUT_IN;
         PORT_DIR <= PORT_DIR_IN;
      end
      else if (enter)
      begin
         PORT_OUT <= PORT_OUT_IN; // R05
         PORT_DIR <= PORT_DIR_IN; // R05
      end
   end
endmodule

// *** hdl/pdw_pkg.sv ***
// Package for the power-down and wake-up controller: modes, timing, port widths.
// Assumes a single 25 MHz core clock; the slow oscillator is modelled as an enable.
package pdw_pkg;
   localparam int CORE_CLK_HZ = 25_000_000;
   localparam int LOW_OSC_HZ = 2_000;
   localparam int LOW_OSC_HALF_CYC = CORE_CLK_HZ / (2 * LOW_OSC_HZ);
   localparam int WDT_PRE_DIV = 8;
   localparam int WDT_MIN_LOG2 = 5;
   localparam int WDT_MAX_LOG2 = 11;
   localparam int OSC_SETTLE_US = 64;
   localparam int OSC_SETTLE_CYC = (OSC_SETTLE_US * (CORE_CLK_HZ / 1_000_000) > 0)
      ? OSC_SETTLE_US * (CORE_CLK_HZ / 1_000_000) : 1;
   localparam int PORT_A_W = 8;
   localparam int IRQ_W = 4;
   localparam logic [2:0] WDT_SEL_RST = 3'h3;
   localparam logic [PORT_A_W-1:0] WAKE_EN_RST = 8'h00;

   typedef enum logic [2:0] {
      PDW_RUN,
      PDW_SLEEP,
      PDW_IDLE_MODE_ZERO,
      PDW_IDLE_MODE_ONE,
      PDW_IDLE_MODE_TWO,
      PDW_SETTLE
   } pdw_state_e;

   typedef struct packed {
      logic high_clk_on;
      logic low_clk_on;
      logic cpu_halted;
   } pdw_clk_s;

   typedef struct packed {
      logic pc_sp_reset;
      logic resume_next;
      logic irq_defer;
   } pdw_wake_s;
endpackage

// *** hdl/pdw_wake_det.sv ***
// Wake detector: catches enabled Port A falling edges and fresh interrupts.
// Assumes pins already passed two flops; runs on the always-on core clock.
module pdw_wake_det
#(
   parameter int PW = 8,
   parameter int IW = 4
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic arm,
   input wire logic [PW-1:0] pin_sync,
   input wire logic [PW-1:0] wake_en,
   input wire logic [IW-1:0] irq_req,
   output logic pin_wake,
   output logic irq_wake
);
   initial
   begin
      if (PW < 1 || IW < 1) $error("pdw_wake_det: widths must be positive");
   end

   logic [PW-1:0] pin_last_ff;
   logic [IW-1:0] irq_mask_ff;

   // Previous pin level for edge detection
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pin_last_ff <= '1;
      else
         pin_last_ff <= pin_sync;
   end

   // Requests already pending at entry lose their wake right
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_mask_ff <= '0;
      else if (arm)
         irq_mask_ff <= irq_req; // R14
   end

   assign pin_wake = |(pin_last_ff & ~pin_sync & wake_en); // R11 R19
   assign irq_wake = |(irq_req & ~irq_mask_ff); // R14 R19
endmodule

// *** hdl/pdw_wdt.sv ***
// Watchdog: slow oscillator enable divided by eight, then by 2^5..2^11.
// Assumes osc_tick is a one-cycle enable on the core clock.
module pdw_wdt
#(
   parameter int SEL_W = 3
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic osc_tick,
   input wire logic wdt_clear,
   input wire logic [SEL_W-1:0] sel,
   output logic overflow
);
   import pdw_pkg::*;

   initial
   begin
      if (SEL_W != 3) $error("pdw_wdt: select must be three bits");
   end

   logic [2:0] pre_ff;
   logic [WDT_MAX_LOG2-1:0] cnt_ff;
   logic wdt_tick;
   logic [WDT_MAX_LOG2-1:0] limit;

   // Ratio table: 000 and 001 both give 2^5
   function automatic logic [WDT_MAX_LOG2-1:0] top_of(input logic [2:0] s);
      int unsigned sh;
      sh = (s < 3'h1) ? 0 : int'(s) - 1;
      top_of = WDT_MAX_LOG2'((32'h0000_0020 << sh) - 32'h0000_0001);
   endfunction

   assign wdt_tick = osc_tick && (pre_ff == 3'(WDT_PRE_DIV - 1)); // R16
   assign limit = top_of(sel); // R17

   // Divide-by-eight prescaler
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pre_ff <= 3'h0;
      else if (wdt_clear)
         pre_ff <= 3'h0;
      else if (osc_tick)
         pre_ff <= pre_ff + 3'h1; // R16
   end

   // Timeout counter; clear wins, counting resumes next tick
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_ff <= '0;
         overflow <= 1'b0;
      end
      else
      begin
         overflow <= 1'b0;
         if (wdt_clear)
            cnt_ff <= '0; // R07
         else if (wdt_tick)
         begin
            if (cnt_ff >= limit)
            begin
               cnt_ff <= '0;
               overflow <= 1'b1; // R17
            end
            else
               cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end
endmodule
